// ==== rtl/msc_stop_ctrl.sv ====
// stop request sequencer with parameter registers for halt and quick stop
`include "msc_consts.svh"
`default_nettype none
module msc_stop_ctrl
    import msc_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_ce,
    input  wire logic        i_halt_pin,
    input  wire logic        i_halt_pin_en,
    input  wire logic        i_halt_cmd,
    input  wire logic        i_qstop_cmd,
    input  wire logic        i_err_valid,
    input  wire logic [2:0]  i_err_class,
    input  wire logic        i_stop_clear,
    input  wire logic        i_standstill,
    input  wire logic        i_motion_start,
    input  wire logic        i_vel_profile,
    input  wire logic [15:0] i_stage_peak_current,
    input  wire logic        i_par_wr,
    input  wire logic        i_par_rd,
    input  wire logic [15:0] i_par_addr,
    input  wire logic [31:0] i_par_wdata,
    output logic      [31:0] o_par_rdata,
    output logic             o_par_rvalid,
    output logic             o_par_reject,
    output logic             o_stop_active,
    output logic             o_ramp_torque,
    output logic      [31:0] o_ramp_rate,
    output logic      [15:0] o_ramp_current,
    output logic             o_resume,
    output logic      [3:0]  o_op_state
);
    msc_state_e state_reg;          // sequencer state
    msc_state_e state_next;         // next sequencer state
    logic [2:0] pin_sync_reg;       // halt pin synchroniser chain
    logic       pin_halt_reg;       // filtered halt pin level
    msc_code_t  halt_react_reg;     // halt selector
    msc_code_t  qs_react_reg;       // quick stop selector
    msc_code_t  halt_cur_reg;       // halt current
    msc_code_t  qs_cur_reg;         // quick stop current
    msc_rate_t  prof_decel_reg;     // profile deceleration as written
    msc_rate_t  qs_decel_reg;       // quick stop deceleration as written
    msc_rate_t  prof_act_reg;       // profile rate of current movement
    msc_rate_t  qs_act_reg;         // quick stop rate of current movement
    logic       halt_req;           // combined halt request
    logic       qs_req;             // combined quick stop request
    logic       wr_ok;              // write value legal for its address
    msc_ramp_if rif();

    // pin crosses three flops; a change counts once stages two and three agree
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            pin_sync_reg <= 3'h0;
            pin_halt_reg <= 1'b0;
        end else if (i_ce) begin
            pin_sync_reg <= {pin_sync_reg[1:0], i_halt_pin};
            if (pin_sync_reg[1] == pin_sync_reg[2]) begin
                pin_halt_reg <= pin_sync_reg[2];
            end
        end
    end

    // pin counts only when the master gave it the halt function
    assign halt_req = (pin_halt_reg && i_halt_pin_en) || i_halt_cmd;
    assign qs_req   = i_qstop_cmd || (i_err_valid &&
                      (i_err_class == `MSC_ERR_CLASS_1 ||
                       i_err_class == `MSC_ERR_CLASS_2));

    // legality of a write, per register
    always_comb begin
        unique case (i_par_addr)
            `MSC_ADDR_HALT_REACT: wr_ok = (i_par_wdata[15:0] == `MSC_HALT_DECEL) ||
                                          (i_par_wdata[15:0] == `MSC_HALT_TORQUE);
            `MSC_ADDR_QS_REACT: wr_ok = (i_par_wdata[15:0] == `MSC_QS_TORQUE_FAULT) ||
                                        (i_par_wdata[15:0] == `MSC_QS_DECEL_FAULT) ||
                                        (i_par_wdata[15:0] == `MSC_QS_DECEL_STAY) ||
                                        (i_par_wdata[15:0] == `MSC_QS_TORQUE_STAY);
            `MSC_ADDR_QS_DECEL: wr_ok = (i_par_wdata >= `MSC_QS_DECEL_MIN) &&
                                        (i_par_wdata <= `MSC_QS_DECEL_MAX);
            `MSC_ADDR_PROFILE_DECEL: wr_ok = (i_par_wdata >= `MSC_PROF_DECEL_MIN) &&
                                             (i_par_wdata <= `MSC_PROF_DECEL_MAX);
            `MSC_ADDR_HALT_CURRENT,
            `MSC_ADDR_QS_CURRENT: wr_ok = (i_par_wdata[15:0] <= i_stage_peak_current) &&
                                          (i_par_wdata[31:16] == 16'h0000);
            default: wr_ok = 1'b0;  // status and unmapped take no writes
        endcase
    end

    // parameter writes; an illegal value leaves the old one standing
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            halt_react_reg <= `MSC_HALT_TORQUE;
            qs_react_reg   <= `MSC_QS_TORQUE_STAY;
            halt_cur_reg   <= `MSC_HALT_CUR_RST;
            qs_cur_reg     <= `MSC_QS_CUR_RST;
            prof_decel_reg <= `MSC_PROF_DECEL_RST;
            qs_decel_reg   <= `MSC_QS_DECEL_RST;
            o_par_reject   <= 1'b0;
        end else if (i_ce) begin
            o_par_reject <= i_par_wr && !wr_ok;
            if (i_par_wr && wr_ok) begin
                unique case (i_par_addr)
                    `MSC_ADDR_HALT_REACT:    halt_react_reg <= i_par_wdata[15:0];
                    `MSC_ADDR_QS_REACT:      qs_react_reg   <= i_par_wdata[15:0];
                    `MSC_ADDR_HALT_CURRENT:  halt_cur_reg   <= i_par_wdata[15:0];
                    `MSC_ADDR_QS_CURRENT:    qs_cur_reg     <= i_par_wdata[15:0];
                    `MSC_ADDR_QS_DECEL:      qs_decel_reg   <= i_par_wdata;
                    `MSC_ADDR_PROFILE_DECEL: prof_decel_reg <= i_par_wdata;
                    default: ;
                endcase
            end
        end
    end

    // rates apply from the next movement, so latch them at its start
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            prof_act_reg <= `MSC_PROF_DECEL_RST;
            qs_act_reg   <= `MSC_QS_DECEL_RST;
        end else if (i_ce && i_motion_start && state_reg == MSC_RUN) begin
            prof_act_reg <= prof_decel_reg;
            qs_act_reg   <= qs_decel_reg;
        end
    end

    // readback; status word shows the operating state code (halt states read as run)
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_par_rdata  <= 32'h0000_0000;
            o_par_rvalid <= 1'b0;
        end else if (i_ce) begin
            o_par_rvalid <= i_par_rd;
            if (i_par_rd) begin
                unique case (i_par_addr)
                    `MSC_ADDR_HALT_REACT:    o_par_rdata <= {16'h0000, halt_react_reg};
                    `MSC_ADDR_QS_REACT:      o_par_rdata <= {16'h0000, qs_react_reg};
                    `MSC_ADDR_HALT_CURRENT:  o_par_rdata <= {16'h0000, halt_cur_reg};
                    `MSC_ADDR_QS_CURRENT:    o_par_rdata <= {16'h0000, qs_cur_reg};
                    `MSC_ADDR_QS_DECEL:      o_par_rdata <= qs_decel_reg;
                    `MSC_ADDR_PROFILE_DECEL: o_par_rdata <= prof_decel_reg;
                    `MSC_ADDR_STATUS:        o_par_rdata <= {28'h0000000, o_op_state};
                    default:                 o_par_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // quick stop outranks halt in every state that can still move
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            MSC_RUN: begin
                if (qs_req) state_next = MSC_QS_DECEL;
                else if (halt_req) state_next = MSC_HALT_DECEL;
            end
            MSC_HALT_DECEL: begin
                if (qs_req) state_next = MSC_QS_DECEL;
                // a release here does not abort the ramp
                else if (i_standstill) state_next = halt_req ? MSC_HALT_STILL : MSC_RUN;
            end
            MSC_HALT_STILL: begin
                if (qs_req) state_next = MSC_QS_DECEL;
                else if (!halt_req) state_next = MSC_RUN;
            end
            MSC_QS_DECEL: begin
                if (i_standstill) state_next = rif.to_fault ? MSC_FAULT : MSC_QS_ACTIVE;
            end
            MSC_QS_ACTIVE,
            MSC_FAULT: begin
                if (i_stop_clear && !qs_req) state_next = MSC_RUN;
            end
        endcase
    end

    // state and registered motion outputs
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            state_reg      <= MSC_RUN;
            o_resume       <= 1'b0;
            o_ramp_torque  <= 1'b0;
            o_ramp_rate    <= `MSC_PROF_DECEL_RST;
            o_ramp_current <= `MSC_HALT_CUR_RST;
        end else if (i_ce) begin
            state_reg      <= state_next;
            // pulse asks the profile to reaccelerate to the old velocity
            o_resume       <= (state_reg == MSC_HALT_DECEL || state_reg == MSC_HALT_STILL)
                              && state_next == MSC_RUN;
            o_ramp_torque  <= rif.torque;
            o_ramp_rate    <= rif.rate;
            o_ramp_current <= rif.current;
        end
    end

    // ramp selector sees live selectors: they act immediately
    always_comb begin
        rif.stop_is_qs  = (state_next == MSC_QS_DECEL || state_next == MSC_QS_ACTIVE ||
                           state_next == MSC_FAULT);
        rif.vel_profile = i_vel_profile;
        rif.halt_react  = halt_react_reg;
        rif.qs_react    = qs_react_reg;
        rif.halt_cur    = halt_cur_reg;
        rif.qs_cur      = qs_cur_reg;
        rif.stage_peak  = i_stage_peak_current;
        rif.prof_rate   = prof_act_reg;
        rif.qs_rate     = qs_act_reg;
    end

    msc_ramp_select u_msc_ramp_select (
        .rif (rif.sel)
    );

    assign o_stop_active = (state_reg != MSC_RUN);
    assign o_op_state = (state_reg == MSC_FAULT) ? `MSC_OPSTATE_FAULT :
                        (state_reg == MSC_QS_DECEL || state_reg == MSC_QS_ACTIVE) ?
                        `MSC_OPSTATE_QSTOP : `MSC_OPSTATE_RUN;

    // checks beside the logic
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_halt_settled;
        state_reg == MSC_HALT_DECEL && i_ce && i_standstill && !qs_req;
    endsequence

    a_qs_entry_run: assert property (i_ce && qs_req && state_reg == MSC_RUN
        |=> state_reg == MSC_QS_DECEL) else $error("quick stop not entered");
    a_halt_entry_run: assert property (i_ce && halt_req && !qs_req && state_reg == MSC_RUN
        |=> state_reg == MSC_HALT_DECEL ##0 o_stop_active)
        else $error("halt not entered");
    a_halt_release_ramp: assert property (i_ce && state_reg == MSC_HALT_DECEL && !halt_req
        && !i_standstill && !qs_req |=> state_reg == MSC_HALT_DECEL)
        else $error("halt ramp aborted early");
    a_halt_resume_pulse: assert property (s_halt_settled ##0 !halt_req
        |=> o_resume && state_reg == MSC_RUN ##1 (!o_resume || !$past(i_ce)))
        else $error("no resume after halt");
    a_qs_end_fault: assert property (i_ce && state_reg == MSC_QS_DECEL && i_standstill &&
        (qs_react_reg == `MSC_QS_TORQUE_FAULT || qs_react_reg == `MSC_QS_DECEL_FAULT)
        |=> o_op_state == `MSC_OPSTATE_FAULT) else $error("fault not reached");
    a_qs_end_stay: assert property (i_ce && state_reg == MSC_QS_DECEL && i_standstill &&
        (qs_react_reg == `MSC_QS_DECEL_STAY || qs_react_reg == `MSC_QS_TORQUE_STAY)
        |=> o_op_state == `MSC_OPSTATE_QSTOP) else $error("quick stop state lost");
    a_halt_code_kept: assert property (i_ce && i_par_wr && i_par_addr ==
        `MSC_ADDR_HALT_REACT && !wr_ok |=> $stable(halt_react_reg) && o_par_reject)
        else $error("illegal halt code taken");
    a_torque_no_prof: assert property (i_ce && !i_vel_profile && state_next != MSC_RUN
        |=> o_ramp_torque) else $error("decel ramp without profile");
    a_qs_rate_range: assert property (qs_decel_reg >= `MSC_QS_DECEL_MIN &&
        qs_decel_reg <= `MSC_QS_DECEL_MAX) else $error("quick stop rate out of range");
    a_halt_rate_src: assert property (i_ce && state_next == MSC_HALT_DECEL && i_vel_profile
        |=> o_ramp_rate == $past(prof_act_reg)) else $error("halt rate not profile rate");
endmodule
`default_nettype wire

// ==== inc/msc_consts.svh ====
// constants for the motion stop control block: offsets, codes, limits, reset values
`ifndef MSC_CONSTS_SVH
`define MSC_CONSTS_SVH

// parameter addresses on the fieldbus side (not word aligned)
`define MSC_ADDR_PROFILE_DECEL   16'h0616
`define MSC_ADDR_QS_DECEL        16'h0624
`define MSC_ADDR_HALT_REACT      16'h062E
`define MSC_ADDR_QS_REACT        16'h0630
`define MSC_ADDR_QS_CURRENT      16'h110A
`define MSC_ADDR_HALT_CURRENT    16'h110C
`define MSC_ADDR_STATUS          16'h1200

// halt reaction codes
`define MSC_HALT_DECEL           16'h0001
`define MSC_HALT_TORQUE          16'h0003
// quick stop reaction codes (16-bit two's complement)
`define MSC_QS_TORQUE_FAULT      16'hFFFE
`define MSC_QS_DECEL_FAULT       16'hFFFF
`define MSC_QS_DECEL_STAY        16'h0006
`define MSC_QS_TORQUE_STAY       16'h0007

// rate limits in rpm/s
`define MSC_QS_DECEL_MIN         32'h0000_00C8
`define MSC_QS_DECEL_MAX         32'h002D_C6C0
`define MSC_QS_DECEL_RST         32'h0000_1770
`define MSC_PROF_DECEL_MIN       32'h0000_02EE
`define MSC_PROF_DECEL_MAX       32'h002D_C6C0
`define MSC_PROF_DECEL_RST       32'h0000_02EE

// currents in 0.01 A peak steps; defaults depend on motor, chosen neutral here
`define MSC_HALT_CUR_RST         16'h0064
`define MSC_QS_CUR_RST           16'h0064

// operating state codes reported
`define MSC_OPSTATE_RUN          4'h6
`define MSC_OPSTATE_QSTOP        4'h7
`define MSC_OPSTATE_FAULT        4'h9

// error classes that start a quick stop
`define MSC_ERR_CLASS_1          3'h1
`define MSC_ERR_CLASS_2          3'h2

`endif

// ==== inc/msc_pkg.sv ====
// types shared by the motion stop control modules
`default_nettype none
package msc_pkg;
    typedef enum logic [2:0] {
        MSC_RUN,
        MSC_HALT_DECEL,
        MSC_HALT_STILL,
        MSC_QS_DECEL,
        MSC_QS_ACTIVE,
        MSC_FAULT
    } msc_state_e;
    typedef logic [15:0] msc_code_t;   // selector codes and currents
    typedef logic [31:0] msc_rate_t;   // ramp rates, rpm/s
endpackage
`default_nettype wire

// ==== inc/msc_ramp_if.sv ====
// signals between the stop sequencer and the ramp selector
`default_nettype none
interface msc_ramp_if;
    import msc_pkg::*;
    logic      stop_is_qs;   // 1: quick stop ramp wanted, 0: halt ramp
    logic      vel_profile;  // mode has a velocity motion profile
    msc_code_t halt_react;   // halt selector
    msc_code_t qs_react;     // quick stop selector
    msc_code_t halt_cur;     // halt torque ramp current
    msc_code_t qs_cur;       // quick stop torque ramp current
    msc_code_t stage_peak;   // power stage ceiling
    msc_rate_t prof_rate;    // latched profile deceleration
    msc_rate_t qs_rate;      // latched quick stop deceleration
    logic      torque;       // 1: torque ramp selected
    logic      to_fault;     // quick stop ends in fault
    msc_rate_t rate;         // selected deceleration rate
    msc_code_t current;      // selected torque ramp current
    modport ctrl (output stop_is_qs, vel_profile, halt_react, qs_react, halt_cur,
                  qs_cur, stage_peak, prof_rate, qs_rate,
                  input torque, to_fault, rate, current);
    modport sel  (input stop_is_qs, vel_profile, halt_react, qs_react, halt_cur,
                  qs_cur, stage_peak, prof_rate, qs_rate,
                  output torque, to_fault, rate, current);
endinterface
`default_nettype wire

// ==== rtl/msc_ramp_select.sv ====
// ramp kind, rate and current choice for halt and quick stop
`include "msc_consts.svh"
`default_nettype none
module msc_ramp_select
    import msc_pkg::*;
(
    msc_ramp_if.sel rif
);
    logic      halt_torque;  // halt selector asks for torque ramp
    logic      qs_torque;    // quick stop selector asks for torque ramp
    msc_code_t cur_raw;      // current before the stage ceiling

    // decode selectors; the register only ever holds legal codes
    always_comb begin
        halt_torque = (rif.halt_react == `MSC_HALT_TORQUE);
        qs_torque   = (rif.qs_react == `MSC_QS_TORQUE_FAULT) ||
                      (rif.qs_react == `MSC_QS_TORQUE_STAY);
        rif.to_fault = (rif.qs_react == `MSC_QS_TORQUE_FAULT) ||
                       (rif.qs_react == `MSC_QS_DECEL_FAULT);
    end

    // modes with no velocity profile fall back to the torque ramp
    always_comb begin
        rif.torque = !rif.vel_profile || (rif.stop_is_qs ? qs_torque : halt_torque);
        rif.rate   = rif.stop_is_qs ? rif.qs_rate : rif.prof_rate;
        cur_raw    = rif.stop_is_qs ? rif.qs_cur : rif.halt_cur;
        // clamp again in case the stage rating dropped after the write
        rif.current = (cur_raw > rif.stage_peak) ? rif.stage_peak : cur_raw;
    end
endmodule
`default_nettype wire

// ==== testbench/msc_master_model.sv ====
// fieldbus master model: parameter access and stop commands
`default_nettype none
module msc_master_model (
    input  wire logic        i_clk,
    input  wire logic [31:0] i_rdata,
    input  wire logic        i_rvalid,
    input  wire logic        i_reject,
    output logic             o_wr,
    output logic             o_rd,
    output logic      [15:0] o_addr,
    output logic      [31:0] o_wdata,
    output logic             o_halt,
    output logic             o_qstop
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero, no request pending
    initial begin
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_addr = 16'h0000;
        o_wdata = 32'h0000_0000;
        o_halt = 1'b0;
        o_qstop = 1'b0;
    end

    // one write strobe; released lines go inverted so stale data never looks valid
    task automatic wr(input logic [15:0] a, input logic [31:0] d, output logic rej);
        @(posedge i_clk);
        o_wr <= 1'b1;
        o_addr <= a;
        o_wdata <= d;
        @(posedge i_clk);
        o_wr <= 1'b0;
        o_addr <= ~a;
        o_wdata <= ~d;
        #1 rej = i_reject;
    endtask

    // one read strobe, answer taken one cycle later
    task automatic rd(input logic [15:0] a, output logic [31:0] d, output logic v);
        @(posedge i_clk);
        o_rd <= 1'b1;
        o_addr <= a;
        @(posedge i_clk);
        o_rd <= 1'b0;
        o_addr <= ~a;
        #1 d = i_rdata;
        v = i_rvalid;
    endtask

    // fieldbus halt and quick stop command levels
    task automatic req(input logic h, input logic q);
        @(posedge i_clk);
        o_halt <= h;
        o_qstop <= q;
    endtask
endmodule
`default_nettype wire

// ==== testbench/tb_motion_stop_control.sv ====
// self-checking bench for the stop request sequencer
`default_nettype none
module tb_motion_stop_control;
    import msc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    // one parameter access: read old, write, expect refusal flag, read new
    typedef struct {
        logic [15:0] addr;
        logic [31:0] old;
        logic [31:0] wd;
        logic        rej;
        logic [31:0] nw;
    } msc_row_s;

    logic        clk, rst, pin, pin_en, qcmd, hcmd, err_valid, clear, still, mstart, velp, ce;
    logic [2:0]  err_class;
    logic        wr, rd, rvalid, reject, stop_active, torque, resume;
    logic [15:0] addr, current;
    logic [31:0] wdata, rdata, rate;
    logic [3:0]  op_state;
    int          n_errors, cmp_count;

    // codes, range edges and the read-only status place
    msc_row_s rows [17] = '{
        '{16'h062E, 32'h3, 32'h1, 1'b0, 32'h1},
        '{16'h062E, 32'h1, 32'h2, 1'b1, 32'h1},
        '{16'h0630, 32'h7, 32'hFFFE, 1'b0, 32'hFFFE},
        '{16'h0630, 32'hFFFE, 32'hFFFF, 1'b0, 32'hFFFF},
        '{16'h0630, 32'hFFFF, 32'h6, 1'b0, 32'h6},
        '{16'h0630, 32'h6, 32'h5, 1'b1, 32'h6},
        '{16'h0630, 32'h6, 32'h7, 1'b0, 32'h7},
        '{16'h0624, 32'h1770, 32'hC7, 1'b1, 32'h1770},
        '{16'h0624, 32'h1770, 32'hC8, 1'b0, 32'hC8},
        '{16'h0624, 32'hC8, 32'h2DC6C1, 1'b1, 32'hC8},
        '{16'h0616, 32'h2EE, 32'h2ED, 1'b1, 32'h2EE},
        '{16'h0616, 32'h2EE, 32'h2DC6C0, 1'b0, 32'h2DC6C0},
        '{16'h110A, 32'h64, 32'h201, 1'b1, 32'h64},
        '{16'h110A, 32'h64, 32'h200, 1'b0, 32'h200},
        '{16'h110C, 32'h64, 32'h1, 1'b0, 32'h1},
        '{16'h1200, 32'h6, 32'h0, 1'b1, 32'h6},
        '{16'h062E, 32'h1, 32'h3, 1'b0, 32'h3}
    };

    // free-running system clock, 8 ns period
    always #4 clk = ~clk;

    msc_stop_ctrl u_msc_stop_ctrl (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(ce), .i_halt_pin(pin),
        .i_halt_pin_en(pin_en), .i_halt_cmd(hcmd), .i_qstop_cmd(qcmd),
        .i_err_valid(err_valid), .i_err_class(err_class), .i_stop_clear(clear),
        .i_standstill(still), .i_motion_start(mstart), .i_vel_profile(velp),
        .i_stage_peak_current(16'h0200), .i_par_wr(wr), .i_par_rd(rd),
        .i_par_addr(addr), .i_par_wdata(wdata), .o_par_rdata(rdata),
        .o_par_rvalid(rvalid), .o_par_reject(reject), .o_stop_active(stop_active),
        .o_ramp_torque(torque), .o_ramp_rate(rate), .o_ramp_current(current),
        .o_resume(resume), .o_op_state(op_state)
    );

    msc_master_model u_msc_master_model (
        .i_clk(clk), .i_rdata(rdata), .i_rvalid(rvalid), .i_reject(reject),
        .o_wr(wr), .o_rd(rd), .o_addr(addr), .o_wdata(wdata),
        .o_halt(hcmd), .o_qstop(qcmd)
    );

    // compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // wait n edges, then let their updates land
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        logic [31:0] d;
        logic        v;
        logic        r;
        {clk, pin, pin_en, err_valid, clear, still, mstart} = '0;
        {rst, velp, ce} = 3'h7;
        err_class = 3'h0;
        n_errors = 0;
        cmp_count = 0;
        cyc(10);
        check(32'(op_state), 32'h6);
        check(rate, 32'h2EE);
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        // table of parameter accesses
        for (int i = 0; i < 17; i++) begin
            u_msc_master_model.rd(rows[i].addr, d, v);
            check(d, rows[i].old);
            u_msc_master_model.wr(rows[i].addr, rows[i].wd, r);
            check(32'(r), 32'(rows[i].rej));
            u_msc_master_model.rd(rows[i].addr, d, v);
            check({d[31:1], v}, {rows[i].nw[31:1], 1'b1});
            check(32'(d[0]), 32'(rows[i].nw[0]));
        end
        // unmapped place is refused
        u_msc_master_model.wr(16'h0002, 32'h1, r);
        check(32'(r), 32'h1);
        // clock enable low freezes everything: a halt seen then must leave no trace
        ce <= 1'b0;
        u_msc_master_model.req(1'b1, 1'b0);
        cyc(2);
        check(32'(stop_active), 32'h0);
        u_msc_master_model.req(1'b0, 1'b0);
        ce <= 1'b1;
        cyc(2);
        check(32'(stop_active), 32'h0);
        // new movement latches the written rates
        @(posedge clk);
        mstart <= 1'b1;
        @(posedge clk);
        mstart <= 1'b0;
        // halt by torque ramp, released before standstill
        u_msc_master_model.req(1'b1, 1'b0);
        cyc(1);
        check(32'(stop_active), 32'h1);
        check({31'h0, torque}, 32'h1);
        check(32'(current), 32'h1);
        u_msc_master_model.req(1'b0, 1'b0);
        cyc(2);
        check(32'(stop_active), 32'h1);
        @(posedge clk);
        still <= 1'b1;
        cyc(1);
        check({31'h0, resume}, 32'h1);
        cyc(1);
        check({31'h0, resume}, 32'h0);
        still <= 1'b0;
        // halt by deceleration ramp, then a mode without velocity profile
        u_msc_master_model.wr(16'h062E, 32'h1, r);
        u_msc_master_model.req(1'b1, 1'b0);
        cyc(1);
        check({31'h0, torque}, 32'h0);
        check(rate, 32'h2DC6C0);
        @(posedge clk);
        velp <= 1'b0;
        cyc(1);
        check({31'h0, torque}, 32'h1);
        velp <= 1'b1;
        still <= 1'b1;
        u_msc_master_model.req(1'b0, 1'b0);
        cyc(3);
        check(32'(stop_active), 32'h0);
        still <= 1'b0;
        // pin ignored until given the halt function
        pin <= 1'b1;
        cyc(6);
        check(32'(stop_active), 32'h0);
        pin_en <= 1'b1;
        for (int k = 0; k < 8 && stop_active !== 1'b1; k++) begin
            cyc(1);
        end
        check(32'(stop_active), 32'h1);
        if (stop_active !== 1'b1) begin
            final_report();
        end
        pin <= 1'b0;
        still <= 1'b1;
        cyc(8);
        still <= 1'b0;
        // quick stop by command, decel ramp, stays in state 7
        u_msc_master_model.wr(16'h0630, 32'h6, r);
        u_msc_master_model.req(1'b0, 1'b1);
        cyc(1);
        check({op_state, torque, rate[27:0]}, {4'h7, 1'b0, 28'hC8});
        u_msc_master_model.req(1'b0, 1'b0);
        still <= 1'b1;
        cyc(2);
        check(32'(op_state), 32'h7);
        clear <= 1'b1;
        cyc(1);
        check(32'(op_state), 32'h6);
        clear <= 1'b0;
        // error classes: 3 ignored, 1 torque then fault, 2 decel then fault
        u_msc_master_model.wr(16'h0630, 32'hFFFE, r);
        @(posedge clk);
        err_valid <= 1'b1;
        err_class <= 3'h3;
        cyc(1);
        check(32'(stop_active), 32'h0);
        err_class <= 3'h1;
        cyc(1);
        check({op_state, torque, current}, {4'h7, 1'b1, 16'h0200});
        cyc(1);
        check(32'(op_state), 32'h9);
        err_valid <= 1'b0;
        clear <= 1'b1;
        cyc(1);
        check(32'(op_state), 32'h6);
        clear <= 1'b0;
        u_msc_master_model.wr(16'h0630, 32'hFFFF, r);
        @(posedge clk);
        err_valid <= 1'b1;
        err_class <= 3'h2;
        @(posedge clk);
        err_valid <= 1'b0;
        #1;
        check({28'h0, op_state}, 32'h7);
        check({31'h0, torque}, 32'h0);
        cyc(1);
        check(32'(op_state), 32'h9);
        final_report();
    end
endmodule
`default_nettype wire
